/* File: rtl/dpgio_defines.svh */
// Register indices, field positions and reset values of the dual port GPIO
`ifndef DPGIO_DEFINES_SVH
`define DPGIO_DEFINES_SVH
// Register indices; byte address is four times the index
`define DPGIO_IDX_PA_DATA 10'h005
`define DPGIO_IDX_PA_DIR 10'h085
`define DPGIO_IDX_ACFG 10'h09f
`define DPGIO_IDX_PB_DATA 10'h006
`define DPGIO_IDX_PB_DIR 10'h086
`define DPGIO_IDX_OPTION 10'h081
`define DPGIO_IDX_INTCTL 10'h0c0
`define DPGIO_IDX_PERCTL 10'h0c1
// Reset values
`define DPGIO_RST_PA_DIR 6'h3f
`define DPGIO_RST_PB_DIR 8'hff
`define DPGIO_RST_OPTION 8'hff
`define DPGIO_RST_ACFG 3'h0
// Field positions
`define DPGIO_OPT_PULLUP_N 7
`define DPGIO_OPT_EDGE 6
`define DPGIO_INT_CHG_FLAG 0
`define DPGIO_INT_EXT_FLAG 1
`define DPGIO_INT_CHG_EN 2
`define DPGIO_INT_EXT_EN 3
`define DPGIO_PER_TMR_EN 0
`define DPGIO_PER_SS_EN 1
`define DPGIO_PA_TMR_BIT 4
`define DPGIO_PA_SS_BIT 5
`define DPGIO_PB_EXT_BIT 0
// Port A analog-capable pin set (AN0..AN3 and AN4 on bit 5)
`define DPGIO_ANA_ALL 6'h2f
`endif

/* File: rtl/dpgio_pkg.sv */
// Types shared by the dual port GPIO block
package dpgio_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } dpgio_apb_req_type;

  typedef struct packed {
    logic [5:0] pa_sync1;
    logic [5:0] pa_sync2;
    logic [7:0] pb_sync1;
    logic [7:0] pb_sync2;
    logic [5:0] pa_lat;
    logic [5:0] pa_dir;
    logic [2:0] acfg;
    logic [7:0] pb_lat;
    logic [7:0] pb_dir;
    logic [7:0] option;
    logic [3:0] intctl;
    logic [1:0] perctl;
    logic [3:0] old_hi;
    logic ext_prev;
    logic [31:0] rdata;
  } dpgio_state_type;
endpackage

/* File: rtl/dpgio_top.sv */
// Dual port GPIO with pin change and external interrupt flags, APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "dpgio_defines.svh"

module dpgio_top (
  input wire logic mclk,
  input wire logic rst,
  input wire dpgio_pkg::dpgio_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] pa_in,
  output logic [5:0] pa_out,
  output logic [5:0] pa_oe_n,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe_n,
  output logic [7:0] pb_pullup_en,
  output logic [5:0] pa_analog_sel,
  input wire logic sleep_mode,
  output logic wake_req,
  output logic pin_change_irq,
  output logic ext_irq,
  output logic timer_ext_clock,
  output logic serial_select_n
);

  dpgio_pkg::dpgio_state_type st_r;
  dpgio_pkg::dpgio_state_type st_nxt;

  // True when the word address selects the register of the given index
  function automatic logic reg_hit(input logic [11:0] addr,
                                   input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx);
  endfunction

  // Analog pin set for each pin config code; codes 6 and 7 are all digital
  function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
    logic [5:0] m;
    m = 6'h00;
    case (cfg)
      3'h0: m = `DPGIO_ANA_ALL;
      3'h1: m = 6'h0f;
      3'h2: m = 6'h07;
      3'h3: m = 6'h03;
      3'h4: m = 6'h01;
      3'h5: m = 6'h20;
      default: m = 6'h00;
    endcase
    analog_mask = m;
  endfunction

  // Read-modify-write merge: unwritten byte lane keeps the old value passed in (sampled pins, or pa_dir)
  function automatic logic [7:0] rmw(input logic [7:0] pins,
                                     input logic [7:0] wdata,
                                     input logic lane);
    rmw = lane ? wdata : pins;
  endfunction

  logic acc;
  logic setup;
  logic wr;
  logic rd;
  logic hit;
  logic [5:0] ana;
  logic [5:0] pa_gpio;
  logic [5:0] pa_view;
  logic [3:0] chg_live;
  logic chg_mismatch;
  logic ext_edge;
  logic pb_access;
  logic [7:0] pa_lat_merge;
  logic [7:0] pa_dir_merge;

  // Decode of the APB phases; access completes in its first cycle
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign rd = acc & ~apb_req.pwrite;

  // Address decode, unmapped words answer with an error
  always_comb begin
    if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DATA)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DIR)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_ACFG)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DATA)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DIR)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_OPTION)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_INTCTL)) begin
      hit = 1'b1;
    end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PERCTL)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // Pin views after synchronisation; analog pins read as zero digitally
  always_comb begin
    ana = analog_mask(st_r.acfg);
    pa_view = st_r.pa_sync2 & ~ana;
    pa_gpio = 6'h3f;
    // Peripheral inputs take the pin off the GPIO driver
    if (st_r.perctl[`DPGIO_PER_TMR_EN]) begin
      pa_gpio[`DPGIO_PA_TMR_BIT] = 1'b0;
    end
    if (st_r.perctl[`DPGIO_PER_SS_EN]) begin
      pa_gpio[`DPGIO_PA_SS_BIT] = 1'b0;
    end
  end

  // Change compare only on upper pins that are inputs
  assign chg_live = (st_r.pb_sync2[7:4] ^ st_r.old_hi) & st_r.pb_dir[7:4];
  assign chg_mismatch = |chg_live;
  assign pb_access = acc & reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DATA);

  // Merged port A words; the two unused upper bits are cut when stored
  assign pa_lat_merge = rmw({2'h0, pa_view}, apb_req.pwdata[7:0], apb_req.pstrb[0]);
  assign pa_dir_merge = rmw({2'h0, st_r.pa_dir}, apb_req.pwdata[7:0], apb_req.pstrb[0]);

  // Edge select: one picks rising, zero falling
  assign ext_edge = st_r.option[`DPGIO_OPT_EDGE]
                  ? (st_r.pb_sync2[`DPGIO_PB_EXT_BIT] & ~st_r.ext_prev)
                  : (~st_r.pb_sync2[`DPGIO_PB_EXT_BIT] & st_r.ext_prev);

  // Next state of every register of the block
  always_comb begin
    st_nxt = st_r;
    // Two-flop synchronisers; only the second stage feeds logic
    st_nxt.pa_sync1 = pa_in;
    st_nxt.pa_sync2 = st_r.pa_sync1;
    st_nxt.pb_sync1 = pb_in;
    st_nxt.pb_sync2 = st_r.pb_sync1;
    st_nxt.ext_prev = st_r.pb_sync2[`DPGIO_PB_EXT_BIT];

    // Hardware set of the sticky flags; a set in the clear cycle wins
    if (wr && reg_hit(apb_req.paddr, `DPGIO_IDX_INTCTL)) begin
      st_nxt.intctl = apb_req.pstrb[0] ? apb_req.pwdata[3:0] : st_r.intctl;
    end
    if (chg_mismatch) begin
      st_nxt.intctl[`DPGIO_INT_CHG_FLAG] = 1'b1;
    end
    if (ext_edge) begin
      st_nxt.intctl[`DPGIO_INT_EXT_FLAG] = 1'b1;
    end

    // Any port B data access reloads the compare value and ends a mismatch
    if (pb_access) begin
      st_nxt.old_hi = st_r.pb_sync2[7:4];
    end

    // Register writes
    if (wr) begin
      if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DATA)) begin
        st_nxt.pa_lat = pa_lat_merge[5:0];
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DIR)) begin
        st_nxt.pa_dir = pa_dir_merge[5:0];
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_ACFG)) begin
        if (apb_req.pstrb[0]) begin
          st_nxt.acfg = apb_req.pwdata[2:0];
        end
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DATA)) begin
        st_nxt.pb_lat = rmw(st_r.pb_sync2, apb_req.pwdata[7:0],
                            apb_req.pstrb[0]);
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DIR)) begin
        if (apb_req.pstrb[0]) begin
          st_nxt.pb_dir = apb_req.pwdata[7:0];
        end
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_OPTION)) begin
        if (apb_req.pstrb[0]) begin
          st_nxt.option = apb_req.pwdata[7:0];
        end
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PERCTL)) begin
        if (apb_req.pstrb[0]) begin
          st_nxt.perctl = apb_req.pwdata[1:0];
        end
      end
    end

    // Read data captured in the setup cycle so prdata comes from a flop
    if (setup && !apb_req.pwrite) begin
      st_nxt.rdata = 32'h0000_0000;
      if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DATA)) begin
        st_nxt.rdata[5:0] = pa_view;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PA_DIR)) begin
        st_nxt.rdata[5:0] = st_r.pa_dir;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_ACFG)) begin
        st_nxt.rdata[2:0] = st_r.acfg;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DATA)) begin
        st_nxt.rdata[7:0] = st_r.pb_sync2;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PB_DIR)) begin
        st_nxt.rdata[7:0] = st_r.pb_dir;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_OPTION)) begin
        st_nxt.rdata[7:0] = st_r.option;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_INTCTL)) begin
        st_nxt.rdata[3:0] = st_r.intctl;
      end else if (reg_hit(apb_req.paddr, `DPGIO_IDX_PERCTL)) begin
        st_nxt.rdata[1:0] = st_r.perctl;
      end
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.pa_dir <= `DPGIO_RST_PA_DIR;
      st_r.pb_dir <= `DPGIO_RST_PB_DIR;
      st_r.option <= `DPGIO_RST_OPTION;
      st_r.acfg <= `DPGIO_RST_ACFG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // APB answer: no wait states, error on unmapped words
  assign pready = acc;
  assign pslverr = acc & ~hit;
  assign prdata = st_r.rdata;

  // Port A drivers; bit 4 can only pull low since it is open drain
  always_comb begin
    pa_out = st_r.pa_lat;
    pa_oe_n = st_r.pa_dir | ~pa_gpio;
    pa_out[`DPGIO_PA_TMR_BIT] = 1'b0;
    pa_oe_n[`DPGIO_PA_TMR_BIT] = st_r.pa_dir[`DPGIO_PA_TMR_BIT]
                               | st_r.pa_lat[`DPGIO_PA_TMR_BIT]
                               | ~pa_gpio[`DPGIO_PA_TMR_BIT];
  end

  // Port B drivers and pull-ups; pull-ups only on input pins
  assign pb_out = st_r.pb_lat;
  assign pb_oe_n = st_r.pb_dir;
  assign pb_pullup_en = {8{~st_r.option[`DPGIO_OPT_PULLUP_N]}}
                      & st_r.pb_dir;

  // Analog select follows the config field for the analog mux
  assign pa_analog_sel = ana;

  // Peripheral inputs taken from synchronised pins
  assign timer_ext_clock = st_r.pa_sync2[`DPGIO_PA_TMR_BIT];
  assign serial_select_n = st_r.pa_sync2[`DPGIO_PA_SS_BIT]
                         | ~st_r.perctl[`DPGIO_PER_SS_EN];

  // Interrupt requests gated by their enables
  assign pin_change_irq = st_r.intctl[`DPGIO_INT_CHG_FLAG]
                        & st_r.intctl[`DPGIO_INT_CHG_EN];
  assign ext_irq = st_r.intctl[`DPGIO_INT_EXT_FLAG]
                 & st_r.intctl[`DPGIO_INT_EXT_EN];
  // Wake works with no clock-gated path; the flag is level held
  assign wake_req = sleep_mode & pin_change_irq;

endmodule

/* File: dv/dpgio_pins_model.sv */
// Model of the circuitry hanging on the two GPIO ports
`timescale 1ns/1ps
module dpgio_pins_model (
  input wire logic [5:0] pa_out,
  input wire logic [5:0] pa_oe_n,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe_n,
  input wire logic [5:0] pa_ext,
  input wire logic [7:0] pb_ext,
  output logic [5:0] pa_in,
  output logic [7:0] pb_in
);
  // A released pin shows the outside level; a driven pin shows the block
  assign pa_in = (pa_oe_n & pa_ext) | (~pa_oe_n & pa_out);
  assign pb_in = (pb_oe_n & pb_ext) | (~pb_oe_n & pb_out);
endmodule

/* File: dv/dpgio_top_assertions.sv */
// Concurrent checks on the dual port GPIO ports
`timescale 1ns/1ps
module dpgio_top_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire dpgio_pkg::dpgio_apb_req_type apb_req,
  input wire logic pready,
  input wire logic [5:0] pa_in,
  input wire logic [5:0] pa_out,
  input wire logic [5:0] pa_oe_n,
  input wire logic [7:0] pb_oe_n,
  input wire logic [7:0] pb_pullup_en,
  input wire logic [5:0] pa_analog_sel,
  input wire logic sleep_mode,
  input wire logic wake_req,
  input wire logic pin_change_irq,
  input wire logic timer_ext_clock
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wr;
  // Lane-0 write in its access cycle
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb[0];
  chk_ready_access: assert property (apb_req.psel && apb_req.penable |-> pready)
    else $error("pready missing");
  chk_od_low: assert property (pa_out[4] == 1'b0)
    else $error("open drain bit high");
  chk_pullup_out: assert property ((pb_pullup_en & ~pb_oe_n) == 8'h00)
    else $error("pull-up on driven pin");
  chk_wake_sleep: assert property (wake_req == (sleep_mode && pin_change_irq))
    else $error("wake request wrong");
  // Two sync stages, so a level held three samples must have come through
  // The sync flops restart at zero, so skip the two edges right after reset
  chk_tmr_sync: assert property (!$past(rst) && !$past(rst, 2) &&
    $stable(pa_in[4]) [*2] |-> timer_ext_clock == pa_in[4])
    else $error("timer clock lags pin");
  chk_pb_dir_wr: assert property (wr && apb_req.paddr == 12'h218 |=>
    pb_oe_n == $past(apb_req.pwdata[7:0])) else $error("port B enables wrong");
  chk_pa_dir_wr: assert property (wr && apb_req.paddr == 12'h214 |=>
    pa_oe_n[3:0] == $past(apb_req.pwdata[3:0])) else $error("port A enables wrong");
  chk_reset_vals: assert property ($fell(rst) |-> pa_oe_n == 6'h3f &&
    pb_pullup_en == 8'h00 && pa_analog_sel == 6'h2f) else $error("reset state wrong");
endmodule
bind dpgio_top dpgio_top_assertions u_dpgio_top_assertions (.mclk(mclk), .rst(rst),
  .apb_req(apb_req), .pready(pready), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
  .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pullup_en), .pa_analog_sel(pa_analog_sel),
  .sleep_mode(sleep_mode), .wake_req(wake_req), .pin_change_irq(pin_change_irq),
  .timer_ext_clock(timer_ext_clock));

/* File: dv/tb.sv */
// Self-checking bench for the dual port GPIO block
`timescale 1ns/1ps
`include "dpgio_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module tb;
  typedef struct packed {logic w; logic [9:0] ix; logic [7:0] d;} dpgio_row_type;
  dpgio_pkg::dpgio_apb_req_type req;
  logic mclk, rst, sleep_mode, pready, slverr, err, wake_req, chg_irq, ext_irq, tmr_clk, ss_n;
  logic [31:0] prdata, q;
  logic [5:0] pa_in, pa_out, pa_oe_n, pa_ana, pa_ext;
  logic [7:0] pb_in, pb_out, pb_oe_n, pb_pu, pb_ext;
  int error_cnt, num_checks, cyc;
  // Register rows: writes, and reads with the value they must return
  dpgio_row_type rows [12] = '{'{1'b0, `DPGIO_IDX_PA_DIR, 8'h3f},
    '{1'b0, `DPGIO_IDX_PB_DIR, 8'hff}, '{1'b0, `DPGIO_IDX_OPTION, 8'hff},
    '{1'b0, `DPGIO_IDX_ACFG, 8'h00}, '{1'b0, `DPGIO_IDX_INTCTL, 8'h00},
    '{1'b1, `DPGIO_IDX_PA_DIR, 8'hff}, '{1'b0, `DPGIO_IDX_PA_DIR, 8'h3f},
    '{1'b1, `DPGIO_IDX_ACFG, 8'h07}, '{1'b0, `DPGIO_IDX_ACFG, 8'h07},
    '{1'b1, `DPGIO_IDX_PB_DIR, 8'hf0}, '{1'b1, `DPGIO_IDX_OPTION, 8'h7f},
    '{1'b0, 10'h004, 8'h00}};
  dpgio_top u_dpgio_top (.mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(slverr), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pu),
    .pa_analog_sel(pa_ana), .sleep_mode(sleep_mode), .wake_req(wake_req),
    .pin_change_irq(chg_irq), .ext_irq(ext_irq), .timer_ext_clock(tmr_clk),
    .serial_select_n(ss_n));
  dpgio_pins_model u_dpgio_pins_model (.pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out),
    .pb_oe_n(pb_oe_n), .pa_ext(pa_ext), .pb_ext(pb_ext), .pa_in(pa_in), .pb_in(pb_in));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard, well above the roughly 120 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  // One APB transfer; lane 0 strobe given by s, answer taken at the pready edge
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d, input logic s);
    req <= '{1'b1, 1'b0, w, {ix, 2'b00}, {24'h0, d}, {4{s}}};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = slverr;
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence: register rows, then pin behaviour cases
  initial begin
    rst = 1'b1;
    sleep_mode = 1'b0;
    req = '0;
    pa_ext = 6'h3f;
    pb_ext = 8'h00;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].ix, rows[i].d, 1'b1);
      if (!rows[i].w) `CHK(q, {24'h0, rows[i].d})
    end
    `CHK({err, pb_pu}, {1'b1, 8'hf0})
    pa_ext <= 6'h2a;
    apb(1'b1, `DPGIO_IDX_PA_DATA, 8'h15, 1'b1);
    apb(1'b0, `DPGIO_IDX_PA_DATA, 8'h00, 1'b1);
    `CHK(q, 32'h2a)
    // Strobe-less write must still reload the latch from the pins
    apb(1'b1, `DPGIO_IDX_PA_DATA, 8'h00, 1'b0);
    apb(1'b1, `DPGIO_IDX_PA_DIR, 8'h00, 1'b1);
    `CHK({pa_out, pa_oe_n}, {6'h2a, 6'h00})
    apb(1'b1, `DPGIO_IDX_PA_DIR, 8'h3f, 1'b1);
    pa_ext <= 6'h3f;
    apb(1'b1, `DPGIO_IDX_ACFG, 8'h00, 1'b1);
    apb(1'b0, `DPGIO_IDX_PA_DATA, 8'h00, 1'b1);
    `CHK({q, pa_ana, tmr_clk}, {32'h10, 6'h2f, 1'b1})
    apb(1'b1, `DPGIO_IDX_ACFG, 8'h07, 1'b1);
    pa_ext <= 6'h1f;
    apb(1'b1, `DPGIO_IDX_PA_DIR, 8'h00, 1'b1);
    apb(1'b1, `DPGIO_IDX_PERCTL, 8'h02, 1'b1);
    repeat (2) @(posedge mclk);
    `CHK({ss_n, pa_oe_n[5]}, 2'b01)
    apb(1'b1, `DPGIO_IDX_INTCTL, 8'h0c, 1'b1);
    apb(1'b0, `DPGIO_IDX_PB_DATA, 8'h00, 1'b1);
    pb_ext <= 8'h10;
    repeat (4) @(posedge mclk);
    `CHK(chg_irq, 1'b1)
    sleep_mode <= 1'b1;
    apb(1'b1, `DPGIO_IDX_INTCTL, 8'h0c, 1'b1);
    `CHK({chg_irq, wake_req}, 2'b11)
    apb(1'b1, `DPGIO_IDX_PB_DATA, 8'h00, 1'b1);
    apb(1'b1, `DPGIO_IDX_INTCTL, 8'h0c, 1'b1);
    `CHK({chg_irq, wake_req}, 2'b00)
    // Bit 4 turns output and differs from the compare latch: must be ignored
    apb(1'b1, `DPGIO_IDX_PB_DIR, 8'h0f, 1'b1);
    repeat (4) @(posedge mclk);
    `CHK(chg_irq, 1'b0)
    `CHK({pb_out, pb_oe_n}, {8'h00, 8'h0f})
    pb_ext <= 8'h11;
    repeat (4) @(posedge mclk);
    `CHK(ext_irq, 1'b1)
    apb(1'b1, `DPGIO_IDX_OPTION, 8'h3f, 1'b1);
    apb(1'b1, `DPGIO_IDX_INTCTL, 8'h0c, 1'b1);
    `CHK(ext_irq, 1'b0)
    pb_ext <= 8'h10;
    repeat (4) @(posedge mclk);
    `CHK(ext_irq, 1'b1)
    summarize();
  end
endmodule
